/* File: design/clk_sel_pkg.sv */
// Constants, types and the selection decode for the output clock selector.
// Assumes a single 100 MHz reference clock domain.
package clk_sel_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_DSEL = 8'h4F;
   localparam logic [7:0] IDX_F1 = 8'h61;
   localparam logic [7:0] IDX_F2 = 8'h62;
   localparam logic [7:0] IDX_STAT = 8'h70;

   // Field positions
   localparam int ALT1_BIT = 2;
   localparam int ALT2_BIT = 5;
   localparam int F1_LSB = 0;
   localparam int F2_LSB = 4;

   // Reset values
   localparam logic DSEL_RST = 1'b0;
   localparam logic [3:0] CODE_RST = 4'h0;

   // Strap width and cycles to wait for the strap synchroniser after reset
   localparam int STRAP_W = 3;
   localparam logic [1:0] BOOT_WAIT = 2'h3;

   // Divide ratio that passes the source straight through
   localparam logic [6:0] RATIO_THRU = 7'h01;

   localparam int NUM_SRC = 9;

   typedef enum logic [3:0] {
      SRC_NONE, SRC_FS2K, SRC_FS8K, SRC_DIG1, SRC_DIG2,
      SRC_MAIN, SRC_AUX, SRC_MAIN2, SRC_MREF, SRC_AREF
   } src_t;

   typedef struct packed {
      logic en;
      src_t src;
      logic [6:0] ratio;
   } sel_t;

   function automatic sel_t mk(input src_t src, input logic [6:0] ratio);
      sel_t s;
      s.en = 1'b1;
      s.src = src;
      s.ratio = ratio;
      return s;
   endfunction

   // Maps a 4-bit code to source and ratio; unlisted codes give a disabled output
   function automatic sel_t decode(input logic second, input logic alt,
                                   input logic [3:0] code);
      sel_t s;
      s = '{en: 1'b0, src: SRC_NONE, ratio: RATIO_THRU};
      if (!alt) begin
         case (code)
            4'h1: s = mk(SRC_FS2K, RATIO_THRU);
            4'h2: s = mk(SRC_FS8K, RATIO_THRU);
            4'h3: s = second ? mk(SRC_MAIN, 7'h02) : mk(SRC_DIG2, RATIO_THRU);
            4'h4: s = mk(SRC_DIG1, RATIO_THRU);
            4'h5: s = second ? mk(SRC_MAIN, RATIO_THRU) : mk(SRC_MAIN, 7'h30);
            4'h6: s = mk(SRC_MAIN, 7'h10);
            4'h7: s = mk(SRC_MAIN, 7'h0C);
            4'h8: s = mk(SRC_MAIN, 7'h08);
            4'h9: s = mk(SRC_MAIN, 7'h06);
            4'hA: s = mk(SRC_MAIN, 7'h04);
            4'hB: s = mk(SRC_AUX, 7'h40);
            4'hC: s = mk(SRC_AUX, 7'h30);
            4'hD: s = mk(SRC_AUX, 7'h10);
            4'hE: s = mk(SRC_AUX, 7'h08);
            4'hF: s = mk(SRC_AUX, 7'h04);
            default: s.en = 1'b0;
         endcase
      end else if (!second) begin
         case (code)
            4'h1: s = mk(SRC_MAIN, 7'h40);
            4'h2: s = mk(SRC_AUX, 7'h14);
            4'h3: s = mk(SRC_AUX, 7'h0C);
            4'h4: s = mk(SRC_AUX, 7'h0A);
            4'h5: s = mk(SRC_AUX, 7'h05);
            4'h6: s = mk(SRC_AUX, 7'h02);
            4'h8: s = mk(SRC_MREF, RATIO_THRU);
            default: s.en = 1'b0;
         endcase
      end else begin
         case (code)
            4'h1: s = mk(SRC_AUX, 7'h05);
            4'h2: s = mk(SRC_AUX, 7'h02);
            4'h3: s = mk(SRC_AUX, RATIO_THRU);
            4'h4: s = mk(SRC_MAIN2, 7'h05);
            4'h5: s = mk(SRC_MAIN2, 7'h02);
            4'h6: s = mk(SRC_MAIN2, RATIO_THRU);
            4'h7: s = mk(SRC_AREF, RATIO_THRU);
            4'h8: s = mk(SRC_MREF, RATIO_THRU);
            default: s.en = 1'b0;
         endcase
      end
      return s;
   endfunction

endpackage

/* File: design/regs_if.sv */
// Register access path between the bus slave and the selector core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface regs_if;
   logic wr_en;
   logic [7:0] wr_idx;
   logic [7:0] wr_data;
   logic [7:0] rd_idx;
   logic [7:0] rd_data;

   modport slave (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
   modport core (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface

/* File: design/ahb_reg_slave.sv */
// AHB-Lite slave: zero-wait writes, one wait state on reads.
// Assumes single word transfers; answers OKAY to everything.
`timescale 1ns/1ps
module ahb_reg_slave (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   regs_if.slave bus
);
   logic take;
   logic ph_wr_r;
   logic ph_rd_r;
   logic [7:0] ph_idx_r;

   assign take = hsel_i && htrans_i[1] && hready_i && (hsize_i == 3'h2);

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ph_wr_r <= 1'b0;
         ph_rd_r <= 1'b0;
         ph_idx_r <= 8'h00;
      end else begin
         ph_wr_r <= take && hwrite_i;
         ph_rd_r <= take && !hwrite_i;
         if (take) begin
            ph_idx_r <= haddr_i[9:2];
         end
      end
   end

   // Read data is fetched in the wait state so a write just before is seen
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hreadyout_o <= 1'b1;
         hrdata_o <= 32'h0000_0000;
      end else begin
         hreadyout_o <= !(take && !hwrite_i);
         if (ph_rd_r) begin
            hrdata_o <= {24'h00_0000, bus.rd_data};
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hresp_o <= 1'b0;
      end else begin
         hresp_o <= 1'b0;
      end
   end

   assign bus.wr_en = ph_wr_r;
   assign bus.wr_idx = ph_idx_r;
   assign bus.wr_data = hwdata_i[7:0];
   assign bus.rd_idx = ph_idx_r;
endmodule

/* File: design/edge_divider.sv */
// Divides a sampled source clock by counting its rising edges.
// Assumes the source was synchronised and is slower than a quarter of ref_clk_i.
`timescale 1ns/1ps
module edge_divider
   import clk_sel_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic en_i,
   input wire logic [3:0] src_i,
   input wire logic src_lvl_i,
   input wire logic src_rise_i,
   input wire logic [6:0] ratio_i,
   output logic clk_o
);
   logic [6:0] cnt_r;
   logic [10:0] cfg_r;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_r <= 11'h000;
      end else begin
         cfg_r <= {src_i, ratio_i};
      end
   end

   // Restart the count whenever the selection changes
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_r <= 7'h00;
      end else if (!en_i || ({src_i, ratio_i} != cfg_r)) begin
         cnt_r <= 7'h00;
      end else if (src_rise_i) begin
         cnt_r <= (cnt_r == ratio_i - 7'h01) ? 7'h00 : cnt_r + 7'h01;
      end
   end

   // High for the first half of the count, so odd ratios are near 50 percent
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clk_o <= 1'b0;
      end else if (!en_i) begin
         clk_o <= 1'b0;
      end else if (ratio_i == RATIO_THRU) begin
         clk_o <= src_lvl_i;
      end else begin
         clk_o <= (cnt_r < (ratio_i >> 1));
      end
   end
endmodule

/* File: design/out_clk_select.sv */
// Output clock frequency selector with its configuration registers.
// Assumes source clocks arrive asynchronously and are sampled at 100 MHz.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
// What this block does
// - Decode-select bit 2 picks first table
// - Decode-select bit 5 picks second table
// - First code in bits 3:0, rest zero
// - Second code in bits 7:4, rest zero
// - Code 0000 disables output, held low
// - First standard: 2kHz and 8kHz codes
// - First standard: synth two, synth one
// - First standard: main PLL divided 48..4
// - Both standard: aux PLL divided 64..4
// - First alternate: main/64, aux dividers
// - First alternate: 1000 main reference
// - Second standard: frames, main/2, synth, main
// - Second standard: main PLL divided 16..4
// - Reset defaults loaded from strap pins
// - Decode-select reads zero after reset
// - Second alternate: aux, main2, references
module out_clk_select
   import clk_sel_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   input wire logic first_out_default_straps_i [STRAP_W],
   input wire logic second_out_default_straps_i [STRAP_W],
   input wire logic frame_2k_i,
   input wire logic frame_8k_i,
   input wire logic digital_synth_one_i,
   input wire logic digital_synth_two_i,
   input wire logic main_analog_pll_i,
   input wire logic aux_analog_pll_i,
   input wire logic main_analog_pll2_i,
   input wire logic main_sel_ref_i,
   input wire logic aux_sel_ref_i,
   output logic first_clock_out_o,
   output logic second_clock_out_o
);
   regs_if bus ();

   logic [NUM_SRC:0] src_raw;
   logic [NUM_SRC:0] src_s1_r;
   logic [NUM_SRC:0] src_s2_r;
   logic [NUM_SRC:0] src_s3_r;
   logic [NUM_SRC:0] src_lvl;
   logic [NUM_SRC:0] src_rise;
   logic [STRAP_W-1:0] strap1_s1_r;
   logic [STRAP_W-1:0] strap1_s2_r;
   logic [STRAP_W-1:0] strap2_s1_r;
   logic [STRAP_W-1:0] strap2_s2_r;
   logic [1:0] boot_cnt_r;
   logic boot_done_r;
   logic first_out_alt_decode_r;
   logic second_out_alt_decode_r;
   logic [3:0] first_out_freq_code_r;
   logic [3:0] second_out_freq_code_r;
   sel_t sel1;
   sel_t sel2;

   ahb_reg_slave u_slave (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .hsel_i(hsel_i),
      .haddr_i(haddr_i),
      .htrans_i(htrans_i),
      .hwrite_i(hwrite_i),
      .hsize_i(hsize_i),
      .hwdata_i(hwdata_i),
      .hready_i(hready_i),
      .hreadyout_o(hreadyout_o),
      .hresp_o(hresp_o),
      .hrdata_o(hrdata_o),
      .bus(bus.slave)
   );

   // Source clocks in enum order; slot zero is the idle source
   assign src_raw = {aux_sel_ref_i, main_sel_ref_i, main_analog_pll2_i, aux_analog_pll_i,
                     main_analog_pll_i, digital_synth_two_i, digital_synth_one_i,
                     frame_8k_i, frame_2k_i, 1'b0};

   // Two stages to resynchronise, a third only for edge detection
   genvar gi;
   generate
      for (gi = 0; gi <= NUM_SRC; gi++) begin : g_sync
         always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               src_s1_r[gi] <= 1'b0;
               src_s2_r[gi] <= 1'b0;
               src_s3_r[gi] <= 1'b0;
            end else begin
               src_s1_r[gi] <= src_raw[gi];
               src_s2_r[gi] <= src_s1_r[gi];
               src_s3_r[gi] <= src_s2_r[gi];
            end
         end
         assign src_lvl[gi] = src_s2_r[gi];
         assign src_rise[gi] = src_s2_r[gi] && !src_s3_r[gi];
      end
   endgenerate

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         strap1_s1_r <= '0;
         strap1_s2_r <= '0;
         strap2_s1_r <= '0;
         strap2_s2_r <= '0;
      end else begin
         strap1_s1_r <= {<<{first_out_default_straps_i}};
         strap1_s2_r <= strap1_s1_r;
         strap2_s1_r <= {<<{second_out_default_straps_i}};
         strap2_s2_r <= strap2_s1_r;
      end
   end

   // Straps settle through the synchroniser before they are loaded once
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         boot_cnt_r <= 2'h0;
         boot_done_r <= 1'b0;
      end else if (!boot_done_r) begin
         boot_cnt_r <= boot_cnt_r + 2'h1;
         boot_done_r <= (boot_cnt_r == BOOT_WAIT);
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         first_out_alt_decode_r <= DSEL_RST;
         second_out_alt_decode_r <= DSEL_RST;
      end else if (boot_done_r && bus.wr_en && (bus.wr_idx == IDX_DSEL)) begin
         first_out_alt_decode_r <= bus.wr_data[ALT1_BIT];
         second_out_alt_decode_r <= bus.wr_data[ALT2_BIT];
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         first_out_freq_code_r <= CODE_RST;
         second_out_freq_code_r <= CODE_RST;
      end else if (!boot_done_r) begin
         if (boot_cnt_r == BOOT_WAIT) begin
            first_out_freq_code_r <= {1'b0, strap1_s2_r};
            second_out_freq_code_r <= {1'b0, strap2_s2_r};
         end
      end else if (bus.wr_en) begin
         if (bus.wr_idx == IDX_F1) begin
            first_out_freq_code_r <= bus.wr_data[F1_LSB +: 4];
         end
         if (bus.wr_idx == IDX_F2) begin
            second_out_freq_code_r <= bus.wr_data[F2_LSB +: 4];
         end
      end
   end

   always_comb begin
      bus.rd_data = 8'h00;
      case (bus.rd_idx)
         IDX_DSEL: begin
            bus.rd_data[ALT1_BIT] = first_out_alt_decode_r;
            bus.rd_data[ALT2_BIT] = second_out_alt_decode_r;
         end
         IDX_F1: bus.rd_data[F1_LSB +: 4] = first_out_freq_code_r;
         IDX_F2: bus.rd_data[F2_LSB +: 4] = second_out_freq_code_r;
         IDX_STAT: bus.rd_data = {4'h0, second_clock_out_o, first_clock_out_o,
                                  sel2.en, sel1.en};
         default: bus.rd_data = 8'h00;
      endcase
   end

   assign sel1 = decode(1'b0, first_out_alt_decode_r, first_out_freq_code_r);
   assign sel2 = decode(1'b1, second_out_alt_decode_r, second_out_freq_code_r);

   edge_divider u_div1 (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .en_i(sel1.en),
      .src_i(sel1.src),
      .src_lvl_i(src_lvl[sel1.src]),
      .src_rise_i(src_rise[sel1.src]),
      .ratio_i(sel1.ratio),
      .clk_o(first_clock_out_o)
   );

   edge_divider u_div2 (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .en_i(sel2.en),
      .src_i(sel2.src),
      .src_lvl_i(src_lvl[sel2.src]),
      .src_rise_i(src_rise[sel2.src]),
      .ratio_i(sel2.ratio),
      .clk_o(second_clock_out_o)
   );

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);

   a_first_alt_write: assert property (
      (boot_done_r && bus.wr_en && bus.wr_idx == IDX_DSEL)
      |=> first_out_alt_decode_r == $past(bus.wr_data[ALT1_BIT]))
      else $error("first table select not taken from bit 2");

   a_second_alt_write: assert property (
      (boot_done_r && bus.wr_en && bus.wr_idx == IDX_DSEL)
      |=> second_out_alt_decode_r == $past(bus.wr_data[ALT2_BIT]))
      else $error("second table select not taken from bit 5");

   a_first_field_zero: assert property (
      (bus.rd_idx == IDX_F1) |-> bus.rd_data[7:4] == 4'h0 &&
      bus.rd_data[3:0] == first_out_freq_code_r)
      else $error("first frequency register layout wrong");

   a_second_field_zero: assert property (
      (bus.rd_idx == IDX_F2) |-> bus.rd_data[3:0] == 4'h0 &&
      bus.rd_data[7:4] == second_out_freq_code_r)
      else $error("second frequency register layout wrong");

   a_code_zero_low: assert property (
      (first_out_freq_code_r == 4'h0) [*2] |-> !first_clock_out_o)
      else $error("disabled first output not low");

   a_main_div48: assert property (
      (!first_out_alt_decode_r && first_out_freq_code_r == 4'h5)
      |-> sel1.en && sel1.src == SRC_MAIN && sel1.ratio == 7'h30)
      else $error("first standard code 0101 not main divided by 48");

   a_aux_div64: assert property (
      (!second_out_alt_decode_r && second_out_freq_code_r == 4'hB)
      |-> sel2.src == SRC_AUX && sel2.ratio == 7'h40)
      else $error("second standard code 1011 not aux divided by 64");

   a_main_thru: assert property (
      (!second_out_alt_decode_r && second_out_freq_code_r == 4'h5) [*2]
      |-> second_clock_out_o == $past(src_lvl[SRC_MAIN]))
      else $error("second output not following main clock");

   a_strap_load: assert property (
      $rose(boot_done_r) |-> first_out_freq_code_r == {1'b0, $past(strap1_s2_r)}
      && second_out_freq_code_r == {1'b0, $past(strap2_s2_r)})
      else $error("strap defaults not loaded");

   a_dsel_reset: assert property (
      !boot_done_r |-> !first_out_alt_decode_r && !second_out_alt_decode_r)
      else $error("decode select not zero after reset");

   a_undef_low: assert property (
      (first_out_alt_decode_r && first_out_freq_code_r == 4'h7) [*2]
      |-> !first_clock_out_o)
      else $error("undefined code drives first output");

   a_first_frames: assert property (
      (!first_out_alt_decode_r && first_out_freq_code_r inside {4'h1, 4'h2})
      |-> sel1.en && sel1.ratio == RATIO_THRU &&
      sel1.src == (first_out_freq_code_r[1] ? SRC_FS8K : SRC_FS2K))
      else $error("first standard frame codes wrong");

   a_first_synths: assert property (
      (!first_out_alt_decode_r && first_out_freq_code_r inside {4'h3, 4'h4})
      |-> sel1.en && sel1.ratio == RATIO_THRU &&
      sel1.src == (first_out_freq_code_r[0] ? SRC_DIG2 : SRC_DIG1))
      else $error("first standard synth codes wrong");

   a_first_alt_main64: assert property (
      (first_out_alt_decode_r && first_out_freq_code_r == 4'h1)
      |-> sel1.en && sel1.src == SRC_MAIN && sel1.ratio == 7'h40)
      else $error("first alternate code 0001 not main divided by 64");

   a_first_alt_ref: assert property (
      (first_out_alt_decode_r && first_out_freq_code_r == 4'h8) [*2]
      |-> first_clock_out_o == $past(src_lvl[SRC_MREF]))
      else $error("first output not following main reference");

   a_second_main_div16: assert property (
      (!second_out_alt_decode_r && second_out_freq_code_r == 4'h6)
      |-> sel2.en && sel2.src == SRC_MAIN && sel2.ratio == 7'h10)
      else $error("second standard code 0110 not main divided by 16");

   a_second_alt_aref: assert property (
      (second_out_alt_decode_r && second_out_freq_code_r == 4'h7)
      |-> sel2.en && sel2.src == SRC_AREF && sel2.ratio == RATIO_THRU)
      else $error("second alternate code 0111 not aux reference");

   c_std_first: cover property (!first_out_alt_decode_r && $rose(first_clock_out_o));
   c_alt_first: cover property (first_out_alt_decode_r && $rose(first_clock_out_o));
   c_std_second: cover property (!second_out_alt_decode_r && $rose(second_clock_out_o));
   c_alt_second: cover property (second_out_alt_decode_r && $rose(second_clock_out_o));
endmodule

/* File: bench/clk_sink_model.sv */
// Downstream consumer model: measures an output clock in reference cycles.
// Assumes the watched clock is a register output that changes on ref_clk_i edges.
`timescale 1ns/1ps
module clk_sink_model (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic clk_i,
   output int period_o,
   output int rises_o
);
   logic last_r;
   int cnt_r;

   // Period is the cycle count between two rising edges
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         last_r <= 1'b0;
         cnt_r <= 0;
         period_o <= 0;
         rises_o <= 0;
      end else begin
         last_r <= clk_i;
         if (clk_i === 1'b1 && last_r === 1'b0) begin
            period_o <= cnt_r + 1;
            rises_o <= rises_o + 1;
            cnt_r <= 0;
         end else begin
            cnt_r <= cnt_r + 1;
         end
      end
   end
endmodule

/* File: bench/tb_output_clock_frequency_select.sv */
// Self-checking bench for the output clock selector and its register bus.
// Assumes sources are offset from ref_clk_i edges so sampled periods are exact.
`timescale 1ns/1ps
module tb_output_clock_frequency_select;
   import clk_sel_pkg::*;
   // Source periods in ns, all distinct and below 25 MHz
   localparam int FS2 = 170;
   localparam int FS8 = 190;
   localparam int DG1 = 130;
   localparam int DG2 = 150;
   localparam int MN = 70;
   localparam int AX = 90;
   localparam int MN2 = 110;
   localparam int MR = 230;
   localparam int AR = 250;
   localparam int SRC_NS [9] = '{FS2, FS8, DG1, DG2, MN, AX, MN2, MR, AR};
   // Expected output period per code; zero means held low
   localparam int T1S [16] = '{0, FS2, FS8, DG2, DG1, MN*48, MN*16, MN*12, MN*8, MN*6,
      MN*4, AX*64, AX*48, AX*16, AX*8, AX*4};
   localparam int T1A [16] = '{0, MN*64, AX*20, AX*12, AX*10, AX*5, AX*2, 0, MR,
      0, 0, 0, 0, 0, 0, 0};
   localparam int T2S [16] = '{0, FS2, FS8, MN*2, DG1, MN, MN*16, MN*12, MN*8, MN*6,
      MN*4, AX*64, AX*48, AX*16, AX*8, AX*4};
   localparam int T2A [16] = '{0, AX*5, AX*2, AX, MN2*5, MN2*2, MN2, AR, MR,
      0, 0, 0, 0, 0, 0, 0};

   logic ref_clk, arst_n, hsel, hwrite, hreadyout, hresp, rdy_s, resp_s, out1, out2;
   logic [31:0] haddr, hwdata, hrdata, rd_s;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic straps1 [STRAP_W];
   logic straps2 [STRAP_W];
   logic [8:0] src;
   int per1, per2, rise1, rise2, err_count, check_count;

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   for (genvar i = 0; i < 9; i++) begin : g_src
      initial begin
         src[i] = 1'b0;
         #3;
         forever #(SRC_NS[i] / 2) src[i] = ~src[i];
      end
   end

   // Bus values as seen at the coming rising edge
   always @(negedge ref_clk) begin
      rdy_s = hreadyout;
      resp_s = hresp;
      rd_s = hrdata;
   end

   out_clk_select dut (
      .ref_clk_i(ref_clk), .arst_n_i(arst_n), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
      .first_out_default_straps_i(straps1), .second_out_default_straps_i(straps2),
      .frame_2k_i(src[0]), .frame_8k_i(src[1]), .digital_synth_one_i(src[2]),
      .digital_synth_two_i(src[3]), .main_analog_pll_i(src[4]), .aux_analog_pll_i(src[5]),
      .main_analog_pll2_i(src[6]), .main_sel_ref_i(src[7]), .aux_sel_ref_i(src[8]),
      .first_clock_out_o(out1), .second_clock_out_o(out2));

   clk_sink_model sink1 (.ref_clk_i(ref_clk), .arst_n_i(arst_n), .clk_i(out1),
      .period_o(per1), .rises_o(rise1));
   clk_sink_model sink2 (.ref_clk_i(ref_clk), .arst_n_i(arst_n), .clk_i(out2),
      .period_o(per2), .rises_o(rise2));

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic bus_xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wdata,
                           output logic [31:0] rdata);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'b010;
      do @(posedge ref_clk); while (rdy_s !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wdata;
      do @(posedge ref_clk); while (rdy_s !== 1'b1);
      rdata = rd_s;
   endtask

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] unused;
      bus_xfer(1'b1, idx, {24'h0, d}, unused);
   endtask

   task automatic reg_chk(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] got;
      bus_xfer(1'b0, idx, 32'h0, got);
      chk_reg(got, exp);
      chk_reg({31'h0, resp_s}, 32'h0);
   endtask

   task automatic chk_clk(input logic second, input int exp_ns);
      int r0, n, got;
      check_count++;
      got = 0;
      if (exp_ns == 0) begin
         // Let a high level launched before the write clear, then demand steady low
         repeat (2) @(posedge ref_clk);
         repeat (300) begin
            @(negedge ref_clk);
            if ((second ? out2 : out1) !== 1'b0) got = 1;
         end
      end else begin
         r0 = second ? rise2 : rise1;
         n = 0;
         while ((second ? rise2 : rise1) < r0 + 3 && n < 5000) begin
            @(negedge ref_clk);
            n++;
         end
         got = (second ? per2 : per1) * 10;
      end
      if (got != exp_ns) begin
         err_count++;
         $display("Error at %0t: out %0d period got %h expected %h", $time, second, got,
            exp_ns);
      end
   endtask

   task automatic sweep(input logic second, input logic [7:0] dsel, input int tbl [16]);
      reg_wr(IDX_DSEL, dsel);
      for (int c = 0; c < 16; c++) begin
         if (second) reg_wr(IDX_F2, 8'(c << 4));
         else reg_wr(IDX_F1, 8'(c));
         chk_clk(second, tbl[c]);
      end
   endtask

   task automatic test_reset_values();
      reg_chk(IDX_DSEL, 32'h0000_0000);
      reg_chk(IDX_F1, 32'h0000_0005);
      reg_chk(IDX_F2, 32'h0000_0030);
      chk_clk(1'b0, MN * 48);
      $display("test reset values done");
   endtask

   task automatic test_field_widths();
      reg_wr(IDX_F1, 8'hFF);
      reg_chk(IDX_F1, 32'h0000_000F);
      reg_wr(IDX_F2, 8'hFF);
      reg_chk(IDX_F2, 32'h0000_00F0);
      reg_wr(IDX_DSEL, 8'hFF);
      reg_chk(IDX_DSEL, 32'h0000_0024);
      reg_chk(IDX_STAT, 32'h0000_0000);
      reg_wr(8'h50, 8'hA5);
      reg_chk(8'h50, 32'h0000_0000);
      $display("test field widths done");
   endtask

   task automatic test_first_std();
      sweep(1'b0, 8'h20, T1S);
      $display("test first standard done");
   endtask

   task automatic test_first_alt();
      sweep(1'b0, 8'h04, T1A);
      $display("test first alternate done");
   endtask

   task automatic test_second_std();
      sweep(1'b1, 8'h04, T2S);
      $display("test second standard done");
   endtask

   task automatic test_second_alt();
      sweep(1'b1, 8'h20, T2A);
      $display("test second alternate done");
   endtask

   initial begin
      #600000;
      err_count++;
      $display("Error at %0t: timeout got %h expected %h", $time, 32'h0, 32'h1);
      print_verdict();
   end

   initial begin
      err_count = 0;
      check_count = 0;
      arst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      straps1 = '{1'b1, 1'b0, 1'b1};
      straps2 = '{1'b1, 1'b1, 1'b0};
      repeat (8) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
      test_reset_values();
      test_field_widths();
      test_first_std();
      test_first_alt();
      test_second_std();
      test_second_alt();
      print_verdict();
   end
endmodule
